// ### logic/adc_result_serial_port.sv
// Purpose: Serial port that hands each conversion result to a host.
// Assumes: CONV_START_I and RESULT_I come from the converter core on
//          CLOCK_I; RESULT_I is offset binary and stable at the end.
// Notes:   Select, mode and coding pins pass two flops; the shift clock pin clocks the link directly.
//
// Functional notes
// RQ1: Mode pin high selects self-clocked mode, shift clock is driven.
// RQ2: Mode pin low selects external clock mode, shift clock is input.
// RQ3: Self-clocked shift clock is made from the master clock.
// RQ4: Self-clocked, chip select high: data and clock pins float.
// RQ5: Self-clocked, select low at ready fall: word leaves MSB first.
// RQ6: Self-clocked data changes on each generated rising clock edge.
// RQ7: Host latches each bit on the next rising clock edge.
// RQ8: Self-clocked, ready returns high after the last bit.
// RQ9: External mode loads the result as ready goes low.
// RQ10: Host lowers select after ready falls, or holds it low.
// RQ11: Host toggles the clock; device presents the next bit each time.
// RQ12: Once a read starts the output register is not reloaded.
// RQ13: Unread result is overwritten by the next conversion.
// RQ14: Select low, no read: ready rises before next end, falls on load.
// RQ15: That early rise comes exactly two master cycles before the end.
// RQ16: Coding pin high gives two's complement, low offset binary.
// RQ17: Each conversion end loads the word and drives ready low; the code skips the load while a host read or a self-clocked shift is under way.
// RQ18: External mode also shifts MSB first, data floats when deselected.
// RQ19: External mode, ready rises after the host takes the last bit.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_cfg.svh"

module adc_result_serial_port (
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    input wire logic SHIFT_CLK_I,
    input wire logic CONV_START_I,
    input wire logic [`WORD_BITS-1:0] RESULT_I,
    input wire logic CS_N_I,
    input wire logic PORT_CLOCK_SOURCE_SELECT_I,
    input wire logic CODING_POLARITY_SELECT_I,
    output logic READY_N_O,
    output logic SERIAL_RESULT_OUT_O,
    output logic SERIAL_RESULT_OUT_OE_O,
    output logic SHIFT_CLK_O,
    output logic SHIFT_CLK_OE_O
);

    // ----------------------------------------
    // Link side
    // ----------------------------------------
    sec_link_if lnk ();

    sec_shift_link u_link (
        .shift_clk_i(SHIFT_CLK_I),
        .arst_n_i(ARST_N_I),
        .lnk(lnk.link)
    );

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [`SYNC_N-1:0] async_in;
    logic [`SYNC_N-1:0] sync1;
    logic [`SYNC_N-1:0] sync2;
    localparam logic [`SYNC_N-1:0] SYNC_RST_V = `SYNC_RST;

    assign async_in = {lnk.done, lnk.busy, CODING_POLARITY_SELECT_I,
                       PORT_CLOCK_SOURCE_SELECT_I, CS_N_I};

    for (genvar i = 0; i < `SYNC_N; i++) begin : g_sync
        always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
                sync1[i] <= SYNC_RST_V[i];
                sync2[i] <= SYNC_RST_V[i];
            end else begin
                sync1[i] <= async_in[i];
                sync2[i] <= sync1[i];
            end
        end
    end

    logic cs_n_s;
    logic mode_ssc;
    logic coding_s;
    logic busy_s;
    logic done_s;

    assign cs_n_s = sync2[0];
    assign mode_ssc = sync2[1];
    assign coding_s = sync2[2];
    assign busy_s = sync2[3];
    assign done_s = sync2[4];

    logic done_q;

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_s;
        end
    end

    logic sec_done_evt;
    logic reading;

    assign sec_done_evt = !mode_ssc && done_s && !done_q;
    // Host owns the port from its first clock until the last bit
    assign reading = !mode_ssc && busy_s && !done_s; // [RQ12]

    // ----------------------------------------
    // Conversion timing
    // ----------------------------------------
    logic conv_run;
    logic [`CONV_W-1:0] conv_cnt;
    logic conv_end;
    logic near_end;

    assign conv_end = conv_run && (conv_cnt == `CONV_CYCLES - 9'h001);
    assign near_end = conv_run
        && (conv_cnt == `CONV_CYCLES - 9'h001 - `RDY_LEAD);

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            conv_run <= 1'b0;
            conv_cnt <= '0;
        end else if (CONV_START_I) begin
            conv_run <= 1'b1;
            conv_cnt <= '0;
        end else if (conv_end) begin
            conv_run <= 1'b0;
            conv_cnt <= '0;
        end else if (conv_run) begin
            conv_cnt <= conv_cnt + 9'h001;
        end
    end

    // ----------------------------------------
    // Output word register
    // ----------------------------------------
    adc_port_pkg::ssc_state_t state;
    logic [`WORD_BITS-1:0] word;
    logic [`WORD_BITS-1:0] coded;
    logic load;
    logic ssc_start;

    // Bipolar flips the sign bit of the offset binary code
    assign coded = {RESULT_I[`WORD_BITS-1] ^ coding_s,
                    RESULT_I[`WORD_BITS-2:0]}; // [RQ16]

    // An unread word is simply replaced; a word in flight is kept
    assign load = conv_end && !reading
        && (state == adc_port_pkg::SSC_IDLE); // [RQ13] [RQ12]
    assign ssc_start = load && mode_ssc && !cs_n_s; // [RQ5]

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            word <= '0;
        end else if (load) begin
            word <= coded; // [RQ9] [RQ17]
        end
    end

    // Restart the link bit counter for every new word
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lnk.clr <= 1'b0;
        end else begin
            lnk.clr <= load; // [RQ9]
        end
    end

    // ----------------------------------------
    // Self-clocked shifter
    // ----------------------------------------
    logic [`WORD_BITS-1:0] ssc_sh;
    logic [`IDX_W-1:0] ssc_edges;
    logic ssc_bit;
    logic ssc_done;

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= adc_port_pkg::SSC_IDLE;
            ssc_sh <= '0;
            ssc_edges <= '0;
            ssc_bit <= 1'b0;
            SHIFT_CLK_O <= 1'b0;
            ssc_done <= 1'b0;
        end else begin
            ssc_done <= 1'b0;
            unique case (state)
                adc_port_pkg::SSC_IDLE: begin
                    SHIFT_CLK_O <= 1'b0;
                    if (ssc_start) begin
                        state <= adc_port_pkg::SSC_SHIFT; // [RQ1]
                        ssc_sh <= coded;
                        ssc_edges <= '0;
                    end
                end
                adc_port_pkg::SSC_SHIFT: begin
                    // Half the master rate keeps the clock in step
                    SHIFT_CLK_O <= ~SHIFT_CLK_O; // [RQ3]
                    if (!SHIFT_CLK_O) begin
                        // Launch on rise; host takes it next rise
                        ssc_bit <= ssc_sh[`WORD_BITS-1]; // [RQ6] [RQ7]
                        ssc_sh <= {ssc_sh[`WORD_BITS-2:0], 1'b0};
                        ssc_edges <= ssc_edges + 5'h01;
                    end else if (ssc_edges == `SSC_EDGES) begin
                        state <= adc_port_pkg::SSC_IDLE;
                        ssc_done <= 1'b1; // [RQ8]
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Ready indication
    // ----------------------------------------
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            READY_N_O <= 1'b1;
        end else if (load) begin
            READY_N_O <= 1'b0; // [RQ17] [RQ14]
        end else if (ssc_done || sec_done_evt) begin
            READY_N_O <= 1'b1; // [RQ8] [RQ19]
        end else if (near_end && !cs_n_s && !reading
                     && (state == adc_port_pkg::SSC_IDLE)) begin
            READY_N_O <= 1'b1; // [RQ14] [RQ15]
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Host holding select low for good just leaves the pins driven
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SERIAL_RESULT_OUT_OE_O <= 1'b0;
            SHIFT_CLK_OE_O <= 1'b0;
        end else begin
            SERIAL_RESULT_OUT_OE_O <= !cs_n_s; // [RQ4] [RQ18] [RQ10]
            SHIFT_CLK_OE_O <= mode_ssc && !cs_n_s; // [RQ1] [RQ2] [RQ4]
        end
    end

    // The external clock moves the bit index, so that path cannot wait
    // for a master edge; the word itself is held still during a read.
    logic sec_bit;

    assign sec_bit = (lnk.idx < `IDX_FULL)
        ? word[`IDX_LAST - lnk.idx] : 1'b0; // [RQ18] [RQ11]
    assign SERIAL_RESULT_OUT_O = mode_ssc ? ssc_bit : sec_bit;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_load_drops_ready: assert property ( // [RQ17]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        load |=> (!READY_N_O && lnk.clr))
        else $error("load did not drop ready");

    a_word_held_read: assert property ( // [RQ12]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (conv_end && reading) |=> $stable(word))
        else $error("word changed during a host read");

    a_ready_lead_two: assert property ( // [RQ15]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (near_end && !READY_N_O && !cs_n_s && !reading && !load
         && !CONV_START_I && state == adc_port_pkg::SSC_IDLE)
        |=> READY_N_O ##1 (READY_N_O && conv_end))
        else $error("early ready rise not two cycles ahead");

    a_ssc_float_desel: assert property ( // [RQ4]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        cs_n_s |=> (!SHIFT_CLK_OE_O && !SERIAL_RESULT_OUT_OE_O))
        else $error("pins driven while deselected");

    a_sec_clk_input: assert property ( // [RQ2]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        !mode_ssc |=> !SHIFT_CLK_OE_O)
        else $error("shift clock driven in external mode");

    a_ssc_word_time: assert property ( // [RQ8]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        ssc_start |=> (!READY_N_O [*8]) ##[40:44] READY_N_O)
        else $error("self-clocked word length wrong");

    a_ssc_data_rise: assert property ( // [RQ6]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        $changed(ssc_bit) |-> $rose(SHIFT_CLK_O))
        else $error("data moved off the rising edge");

    a_ssc_clk_toggles: assert property ( // [RQ3]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (state == adc_port_pkg::SSC_SHIFT && $past(state)
         == adc_port_pkg::SSC_SHIFT) |-> $changed(SHIFT_CLK_O))
        else $error("shift clock not at half master rate");

    a_msb_first: assert property ( // [RQ5]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        ssc_start |=> ##1 (ssc_bit == word[`WORD_BITS-1]))
        else $error("first bit is not the MSB");

    a_coding_sign: assert property ( // [RQ16]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (load && coding_s) |=>
        (word[`WORD_BITS-1] != $past(RESULT_I[`WORD_BITS-1])))
        else $error("two's complement sign not flipped");

    a_sec_done_ready: assert property ( // [RQ19]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (sec_done_evt && !load) |=> READY_N_O)
        else $error("ready not raised after last host bit");

    a_sec_first_bit: assert property ( // [RQ18]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        lnk.clr |-> (sec_bit == word[`WORD_BITS-1]))
        else $error("new word does not start with its MSB");

    a_ssc_oe_mode: assert property ( // [RQ1]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (mode_ssc && !cs_n_s) |=> SHIFT_CLK_OE_O)
        else $error("shift clock not driven in self-clocked mode");

    a_ssc_idle_low: assert property ( // [RQ3]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (state == adc_port_pkg::SSC_IDLE
         && $past(state) == adc_port_pkg::SSC_IDLE) |-> !SHIFT_CLK_O)
        else $error("shift clock moved outside a word");

    a_conv_overwrite: assert property ( // [RQ13]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (conv_end && !reading && state == adc_port_pkg::SSC_IDLE)
        |=> (word == $past(coded)))
        else $error("unread word not replaced at conversion end");

    a_sec_oe_follows: assert property ( // [RQ18]
        @(posedge CLOCK_I) disable iff (!ARST_N_I)
        (!mode_ssc && !cs_n_s) |=> SERIAL_RESULT_OUT_OE_O)
        else $error("data pin not driven while selected");

endmodule // adc_result_serial_port

`default_nettype wire

// ### logic/adc_port_cfg.svh
// Purpose: Constants of the conversion result serial port.
// Assumes: Master clock of 25 MHz drives the conversion timing.
// Notes:   Counts are master clock cycles unless named otherwise.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define WORD_BITS 24
`define IDX_W 5
`define IDX_LAST 5'h17
`define IDX_FULL 5'h18

// ----------------------------------------
// Timing in master clock cycles
// ----------------------------------------
`define CONV_W 9
`define CONV_CYCLES 9'h140
`define RDY_LEAD 9'h002
`define SSC_EDGES 5'h19

// ----------------------------------------
// Synchroniser reset pattern (chip select idles high)
// ----------------------------------------
`define SYNC_N 5
`define SYNC_RST 5'h01

`endif

// ### logic/adc_port_pkg.sv
// Purpose: Types of the conversion result serial port.
// Assumes: Nothing beyond the constants header.
// Notes:   Used by package-qualified names only.
`default_nettype none

package adc_port_pkg;

    typedef enum {SSC_IDLE, SSC_SHIFT} ssc_state_t;

endpackage

`default_nettype wire

// ### logic/sec_link_if.sv
// Purpose: Signals between the master clock side and the link side.
// Assumes: clr is a master flop; idx, busy, done are link flops.
// Notes:   busy and done are levels, synchronised by the receiver.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_cfg.svh"

interface sec_link_if;
    logic clr;
    logic [`IDX_W-1:0] idx;
    logic busy;
    logic done;

    modport master (output clr, input idx, input busy, input done);
    modport link (input clr, output idx, output busy, output done);
endinterface

`default_nettype wire

// ### logic/sec_shift_link.sv
// Purpose: Bit counter clocked by the host shift clock.
// Assumes: Host shifts one bit per full clock, sampling on rising edges.
// Notes:   Cleared asynchronously by the master side on each new word.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_cfg.svh"

module sec_shift_link (
    input wire logic shift_clk_i,
    input wire logic arst_n_i,
    sec_link_if.link lnk
);

    // Clear comes from a master flop, so no glitch reaches the reset
    logic rst_n;
    assign rst_n = arst_n_i & ~lnk.clr;

    // ----------------------------------------
    // Next bit on each falling edge
    // ----------------------------------------
    always_ff @(negedge shift_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lnk.idx <= '0;
        end else if (lnk.idx != `IDX_FULL) begin
            lnk.idx <= lnk.idx + 5'h01; // [RQ11]
        end
    end

    always_ff @(negedge shift_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lnk.busy <= 1'b0;
            lnk.done <= 1'b0;
        end else begin
            lnk.busy <= 1'b1;
            lnk.done <= lnk.done | (lnk.idx == `IDX_LAST); // [RQ19]
        end
    end

    a_idx_in_range: assert property ( // [RQ11]
        @(negedge shift_clk_i) disable iff (!rst_n)
        lnk.idx <= `IDX_FULL)
        else $error("bit index past word end");

endmodule // sec_shift_link

`default_nettype wire

// ### tb/host_reader.sv
// Purpose: Host controller model that reads result words from the port.
// Assumes: The bench resolves the data and clock lines from all enables.
// Notes:   Self-clocked capture runs by itself; external reads are a task.
`timescale 1ns/1ps
`default_nettype none

module host_reader (
    input wire logic clk_line_i,
    input wire logic data_line_i,
    input wire logic ssc_mode_i,
    output logic host_clk_o
);
    logic [23:0] ssc_word;
    logic [23:0] ext_word;
    logic mid;
    int ssc_rises = 0;
    realtime ssc_period = 0.0;
    realtime last_rise = 0.0;

    initial host_clk_o = 1'b0;

    // ----------------------------------------
    // Self-clocked capture
    // ----------------------------------------
    // Mid-bit sample avoids racing the device's launch on the same rise
    always @(negedge clk_line_i) mid <= data_line_i;
    always @(posedge clk_line_i) begin
        if (ssc_mode_i) begin
            if (ssc_rises > 0)
                ssc_word <= {ssc_word[22:0], mid};
            ssc_period = $realtime - last_rise;
            last_rise = $realtime;
            ssc_rises = ssc_rises + 1;
        end
    end

    // ----------------------------------------
    // External clock reads
    // ----------------------------------------
    // Clock stands still between frames; 32 ns period inside them
    task automatic read_ext(input int nbits);
        for (int i = 0; i < nbits; i++) begin
            #16 host_clk_o = 1'b1;
            ext_word = {ext_word[22:0], data_line_i};
            #16 host_clk_o = 1'b0;
        end
    endtask
endmodule // host_reader

`default_nettype wire

// ### tb/testbench.sv
// Purpose: Self-checking bench for the conversion result serial port.
// Assumes: Master clock 40 ns; host shift clock 32 ns within frames.
// Notes:   Released data line shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk, arst_n, conv_start, cs_n, mode_ssc, coding;
    logic [23:0] result;
    logic ready_n, serial_result_out, sdo_oe, sclk_o, sclk_oe, host_clk;
    logic sdo_last = 1'b0;
    wire logic clk_line, data_line;
    int error_cnt = 0;
    int tests_run = 0;
    int rise_n, fall_n;

    // Host clock output is passive low while the device owns the pin
    assign clk_line = sclk_oe ? sclk_o : host_clk;
    assign data_line = sdo_oe ? serial_result_out : ~sdo_last;
    always @(posedge clk) if (sdo_oe) sdo_last <= serial_result_out;

    adc_result_serial_port dut_u (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .SHIFT_CLK_I(clk_line),
        .CONV_START_I(conv_start), .RESULT_I(result), .CS_N_I(cs_n),
        .PORT_CLOCK_SOURCE_SELECT_I(mode_ssc),
        .CODING_POLARITY_SELECT_I(coding), .READY_N_O(ready_n),
        .SERIAL_RESULT_OUT_O(serial_result_out), .SERIAL_RESULT_OUT_OE_O(sdo_oe),
        .SHIFT_CLK_O(sclk_o), .SHIFT_CLK_OE_O(sclk_oe));

    host_reader host_u (.clk_line_i(clk_line), .data_line_i(data_line),
        .ssc_mode_i(mode_ssc), .host_clk_o(host_clk));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s exp=%h seen=%h", what, exp, seen);
        end
    endtask

    // Pins pass two sync flops, so give them four edges to land
    task automatic pins(input logic m, input logic c, input logic b);
        @(posedge clk);
        mode_ssc <= m;
        cs_n <= c;
        coding <= b;
        repeat (4) @(posedge clk);
    endtask

    task automatic convert(input logic [23:0] val);
        @(posedge clk);
        conv_start <= 1'b1;
        result <= val;
        @(posedge clk);
        conv_start <= 1'b0;
        rise_n = 0;
        fall_n = 0;
        for (int n = 1; n <= 330; n++) begin
            @(posedge clk);
            #1;
            if (ready_n === 1'b1 && rise_n == 0) rise_n = n;
            if (ready_n === 1'b0 && fall_n == 0 && rise_n != 0) fall_n = n;
        end
    endtask

    task automatic wait_ready(input int lim);
        for (int n = 0; n < lim && ready_n !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ext_read();
        logic [23:0] v;
        for (int b = 0; b < 2; b++) begin
            v = 24'hC3A51E ^ 24'(b * 24'h0F0F0F);
            pins(1'b0, 1'b1, b[0]);
            convert(v);
            check("ext fall", 24'(fall_n), 24'd320);
            check("ext sdo oe", sdo_oe, 1'b0);
            pins(1'b0, 1'b0, b[0]);
            check("ext sdo oe low cs", sdo_oe, 1'b1);
            check("ext clk oe", sclk_oe, 1'b0);
            host_u.read_ext(24);
            wait_ready(10);
            check("ext ready", ready_n, 1'b1);
            check("ext word", host_u.ext_word, v ^ {b[0], 23'h0});
        end
    endtask

    task automatic t_hold_read();
        pins(1'b0, 1'b0, 1'b0);
        convert(24'h800001);
        host_u.read_ext(12);
        convert(24'h7FFFFE);
        check("held no rise", 24'(rise_n), 24'd0);
        host_u.read_ext(12);
        check("held word", host_u.ext_word, 24'h800001);
        wait_ready(10);
        check("held ready", ready_n, 1'b1);
    endtask

    task automatic t_overwrite();
        convert(24'h123456);
        check("first fall", 24'(fall_n), 24'd320);
        convert(24'hFEDCBA);
        check("early rise", 24'(rise_n), 24'd318);
        check("refall", 24'(fall_n), 24'd320);
        host_u.read_ext(24);
        check("new word", host_u.ext_word, 24'hFEDCBA);
        wait_ready(10);
    endtask

    task automatic t_ssc();
        pins(1'b1, 1'b1, 1'b0);
        convert(24'h5A5A5A);
        check("ssc fall", 24'(fall_n), 24'd320);
        check("ssc float clk", sclk_oe, 1'b0);
        check("ssc float sdo", sdo_oe, 1'b0);
        pins(1'b1, 1'b0, 1'b0);
        host_u.ssc_rises = 0;
        convert(24'h96E1C3);
        check("ssc early", 24'(rise_n), 24'd318);
        check("ssc clk oe", sclk_oe, 1'b1);
        wait_ready(80);
        check("ssc ready", ready_n, 1'b1);
        check("ssc rises", 24'(host_u.ssc_rises), 24'd25);
        check("ssc word", host_u.ssc_word, 24'h96E1C3);
        check("ssc period", host_u.ssc_period == 80.0, 1'b1);
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Eight conversions of about 330 cycles each fit well inside this
    initial begin
        #500us;
        error_cnt++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        conv_start = 1'b0;
        result = 24'h000000;
        cs_n = 1'b1;
        mode_ssc = 1'b0;
        coding = 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("reset ready", ready_n, 1'b1);
        check("reset sdo oe", sdo_oe, 1'b0);
        check("reset clk oe", sclk_oe, 1'b0);
        t_ext_read();
        t_hold_read();
        t_overwrite();
        t_ssc();
        complete_run();
    end
endmodule // testbench

`default_nettype wire
